// ===== lao_pkg.sv
package lao_pkg;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_CYCLES  = (CLK_HZ / 1000) * FLASH_HALF_MS;

	////////////////////////////////////////////////////////////////////////
	// Geometry
	localparam int NUM_CH     = 2;
	localparam int NUM_LIM    = 3;
	localparam int NUM_ALARM  = NUM_CH * NUM_LIM;
	localparam int NUM_SW     = NUM_CH * 2;
	localparam int VAL_W      = 16;
	localparam int SCALER_W   = 32;
	localparam int DIGIT_W    = 4;
	localparam logic [2:0] LAST_DIGIT_SHORT = 3'h3;
	localparam logic [2:0] LAST_DIGIT_LONG  = 3'h7;
	localparam logic [2:0] LAST_ALARM       = 3'h5;
	localparam logic [3:0] FILTER_LAST      = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [VAL_W-1:0]    RST_LIMIT    = 16'h9999;
	localparam logic [SCALER_W-1:0] RST_SCALER   = 32'h00000001;
	localparam logic [VAL_W-1:0]    RST_DIVISOR  = 16'h0001;
	localparam logic [VAL_W-1:0]    RST_DEADBAND = 16'h0000;
	localparam logic [3:0]          RST_FILTER   = 4'h0;
	localparam logic [1:0]          RST_DECPT    = 2'h0;
	localparam logic                RST_LATCH    = 1'b0;
	localparam logic [5:0]          RST_NC       = 6'h00;
	localparam logic                RST_BUZZER   = 1'b1;

	typedef enum logic [3:0] {
		MENU_RUN,
		MENU_FILTER,
		MENU_DECPT,
		MENU_SCALER,
		MENU_DIVISOR,
		MENU_LIMIT,
		MENU_DEADBAND,
		MENU_LATCH,
		MENU_POLARITY,
		MENU_BUZZER
	} lao_menu_t;

	function automatic logic [6:0] lao_filter_value(input logic [3:0] idx);
		case (idx)
			4'h0: lao_filter_value = 7'h01;
			4'h1: lao_filter_value = 7'h02;
			4'h2: lao_filter_value = 7'h04;
			4'h3: lao_filter_value = 7'h06;
			4'h4: lao_filter_value = 7'h0A;
			4'h5: lao_filter_value = 7'h0F;
			4'h6: lao_filter_value = 7'h14;
			4'h7: lao_filter_value = 7'h1E;
			default: lao_filter_value = 7'h3C;
		endcase
	endfunction

endpackage

// ===== lao_limit_alarm.sv
`timescale 1ns/1ps

module lao_limit_alarm #(
	parameter int FLASH_CYCLES = lao_pkg::FLASH_CYCLES
) (
	input  wire logic                         clk,
	input  wire logic                         reset,
	input  wire logic                         ce,
	input  wire logic                         keyUp,
	input  wire logic                         keyDown,
	input  wire logic                         keyNext,
	input  wire logic                         keyData,
	input  wire logic                         keyReset,
	input  wire logic                         keySetup,
	input  wire logic [lao_pkg::VAL_W-1:0]    procVal0,
	input  wire logic [lao_pkg::VAL_W-1:0]    procVal1,
	output logic      [lao_pkg::NUM_SW-1:0]   limitOut,
	output logic      [lao_pkg::NUM_ALARM-1:0] alarmLed,
	output logic                              buzzer,
	output lao_pkg::lao_menu_t                menuItem,
	output logic      [2:0]                   menuSub,
	output logic      [lao_pkg::SCALER_W-1:0] dispValue,
	output logic      [2:0]                   activeDigit,
	output logic                              digitLit,
	output logic                              clearedMsg,
	output logic      [6:0]                   filterValue,
	output logic      [1:0]                   decimalPos,
	output logic      [lao_pkg::SCALER_W-1:0] scalerValue,
	output logic      [lao_pkg::VAL_W-1:0]    divisorValue
);

	localparam int FLASH_W = $clog2(FLASH_CYCLES + 1);
	localparam logic [FLASH_W-1:0] FLASH_LAST = FLASH_W'(FLASH_CYCLES - 1);

	function automatic logic [31:0] stepDigit(input logic [31:0] v,
		input logic [2:0] d, input logic up);
		logic [3:0] nib;
		nib = v[d*4 +: 4];
		stepDigit = v;
		stepDigit[d*4 +: 4] = up ? nib + 4'h1 : nib - 4'h1;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Key synchronisers and edge detection
	logic [5:0] keySync1_ff;
	logic [5:0] keySync2_ff;
	logic [5:0] keyPrev_ff;
	wire  [5:0] keyRaw = {keySetup, keyReset, keyData, keyNext, keyDown, keyUp};
	wire  [5:0] keyRise = keySync2_ff & ~keyPrev_ff;
	wire        upRise    = keyRise[0];
	wire        downRise  = keyRise[1];
	wire        nextRise  = keyRise[2];
	wire        dataRise  = keyRise[3];
	wire        resetRise = keyRise[4];
	wire        setupRise = keyRise[5];
	wire        dataHeld  = keySync2_ff[3];
	wire        stepKey   = upRise | downRise;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			keySync1_ff <= 6'h00;
			keySync2_ff <= 6'h00;
			keyPrev_ff  <= 6'h00;
		end else if (ce) begin
			keySync1_ff <= keyRaw;
			keySync2_ff <= keySync1_ff;
			keyPrev_ff  <= keySync2_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration state
	lao_pkg::lao_menu_t              menu_ff, nxt_menu;
	logic [2:0]                      sub_ff, nxt_sub;
	logic [2:0]                      digit_ff, nxt_digit;
	logic [3:0]                      filter_ff, nxt_filter;
	logic [1:0]                      decpt_ff, nxt_decpt;
	logic [lao_pkg::SCALER_W-1:0]    scaler_ff, nxt_scaler;
	logic [lao_pkg::VAL_W-1:0]       divisor_ff, nxt_divisor;
	logic [lao_pkg::VAL_W-1:0]       deadband_ff, nxt_deadband;
	logic [lao_pkg::VAL_W-1:0]       limits_ff [lao_pkg::NUM_ALARM];
	logic [lao_pkg::VAL_W-1:0]       nxt_limits [lao_pkg::NUM_ALARM];
	logic                            latch_ff, nxt_latch;
	logic [lao_pkg::NUM_ALARM-1:0]   nc_ff, nxt_nc;
	logic                            buzzerOn_ff, nxt_buzzerOn;

	wire inSetup  = menu_ff != lao_pkg::MENU_RUN;
	wire hasSub   = (menu_ff == lao_pkg::MENU_LIMIT) ||
	                (menu_ff == lao_pkg::MENU_POLARITY);
	wire [2:0] lastDigit = (menu_ff == lao_pkg::MENU_SCALER) ?
	                       lao_pkg::LAST_DIGIT_LONG : lao_pkg::LAST_DIGIT_SHORT;

	// Value under digit edit for the current menu item
	wire [31:0] editVal =
		(menu_ff == lao_pkg::MENU_SCALER)   ? scaler_ff :
		(menu_ff == lao_pkg::MENU_DIVISOR)  ? {16'h0000, divisor_ff} :
		(menu_ff == lao_pkg::MENU_DEADBAND) ? {16'h0000, deadband_ff} :
		{16'h0000, limits_ff[sub_ff]};
	wire [31:0] steppedVal = stepDigit(editVal, digit_ff, upRise);

	always_comb begin
		nxt_menu     = menu_ff;
		nxt_sub      = sub_ff;
		nxt_digit    = digit_ff;
		nxt_filter   = filter_ff;
		nxt_decpt    = decpt_ff;
		nxt_scaler   = scaler_ff;
		nxt_divisor  = divisor_ff;
		nxt_deadband = deadband_ff;
		nxt_limits   = limits_ff;
		nxt_latch    = latch_ff;
		nxt_nc       = nc_ff;
		nxt_buzzerOn = buzzerOn_ff;
		if (setupRise) begin
			nxt_menu  = inSetup ? lao_pkg::MENU_RUN : lao_pkg::MENU_FILTER;
			nxt_sub   = 3'h0;
			nxt_digit = 3'h0;
		end else if (inSetup && dataRise) begin
			nxt_digit = 3'h0;
			if (hasSub && sub_ff != lao_pkg::LAST_ALARM) begin
				nxt_sub = sub_ff + 3'h1;
			end else begin
				nxt_sub = 3'h0;
				case (menu_ff)
					lao_pkg::MENU_FILTER:   nxt_menu = lao_pkg::MENU_DECPT;
					lao_pkg::MENU_DECPT:    nxt_menu = lao_pkg::MENU_SCALER;
					lao_pkg::MENU_SCALER:   nxt_menu = lao_pkg::MENU_DIVISOR;
					lao_pkg::MENU_DIVISOR:  nxt_menu = lao_pkg::MENU_LIMIT;
					lao_pkg::MENU_LIMIT:    nxt_menu = lao_pkg::MENU_DEADBAND;
					lao_pkg::MENU_DEADBAND: nxt_menu = lao_pkg::MENU_LATCH;
					lao_pkg::MENU_LATCH:    nxt_menu = lao_pkg::MENU_POLARITY;
					lao_pkg::MENU_POLARITY: nxt_menu = lao_pkg::MENU_BUZZER;
					default:                nxt_menu = lao_pkg::MENU_FILTER;
				endcase
			end
		end else if (inSetup && nextRise) begin
			nxt_digit = (digit_ff >= lastDigit) ? 3'h0 : digit_ff + 3'h1;
		end else if (inSetup && stepKey) begin
			case (menu_ff)
				lao_pkg::MENU_FILTER: begin
					if (upRise)
						nxt_filter = (filter_ff == lao_pkg::FILTER_LAST) ?
						             4'h0 : filter_ff + 4'h1;
					else
						nxt_filter = (filter_ff == 4'h0) ?
						             lao_pkg::FILTER_LAST : filter_ff - 4'h1;
				end
				lao_pkg::MENU_DECPT: begin
					nxt_decpt = upRise ? decpt_ff + 2'h1 : decpt_ff - 2'h1;
				end
				lao_pkg::MENU_SCALER:   nxt_scaler = steppedVal;
				lao_pkg::MENU_DIVISOR:  nxt_divisor = steppedVal[15:0];
				lao_pkg::MENU_LIMIT:    nxt_limits[sub_ff] = steppedVal[15:0];
				lao_pkg::MENU_DEADBAND: nxt_deadband = steppedVal[15:0];
				lao_pkg::MENU_LATCH:    nxt_latch = ~latch_ff;
				lao_pkg::MENU_POLARITY: nxt_nc[sub_ff] = ~nc_ff[sub_ff];
				lao_pkg::MENU_BUZZER:   nxt_buzzerOn = ~buzzerOn_ff;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			menu_ff     <= lao_pkg::MENU_RUN;
			sub_ff      <= 3'h0;
			digit_ff    <= 3'h0;
			filter_ff   <= lao_pkg::RST_FILTER;
			decpt_ff    <= lao_pkg::RST_DECPT;
			scaler_ff   <= lao_pkg::RST_SCALER;
			divisor_ff  <= lao_pkg::RST_DIVISOR;
			deadband_ff <= lao_pkg::RST_DEADBAND;
			for (int i = 0; i < lao_pkg::NUM_ALARM; i++)
				limits_ff[i] <= lao_pkg::RST_LIMIT;
			latch_ff    <= lao_pkg::RST_LATCH;
			nc_ff       <= lao_pkg::RST_NC;
			buzzerOn_ff <= lao_pkg::RST_BUZZER;
		end else if (ce) begin
			menu_ff     <= nxt_menu;
			sub_ff      <= nxt_sub;
			digit_ff    <= nxt_digit;
			filter_ff   <= nxt_filter;
			decpt_ff    <= nxt_decpt;
			scaler_ff   <= nxt_scaler;
			divisor_ff  <= nxt_divisor;
			deadband_ff <= nxt_deadband;
			limits_ff   <= nxt_limits;
			latch_ff    <= nxt_latch;
			nc_ff       <= nxt_nc;
			buzzerOn_ff <= nxt_buzzerOn;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Alarm comparison and release
	logic [lao_pkg::NUM_ALARM-1:0] alarm_ff;
	logic [lao_pkg::NUM_ALARM-1:0] nxt_alarm;
	logic [2:0]                    runSel_ff;
	logic                          cleared_ff;
	wire  [lao_pkg::NUM_ALARM-1:0] overLimit;
	wire  [lao_pkg::NUM_ALARM-1:0] belowLimit;
	wire  [lao_pkg::NUM_ALARM-1:0] belowBand;

	// Reset keys only count in run mode with latching on and Data held
	wire manualReq = !inSetup && latch_ff && dataHeld && resetRise;
	wire manualOk  = manualReq && belowLimit[runSel_ff];

	for (genvar a = 0; a < lao_pkg::NUM_ALARM; a++) begin : g_alarm
		wire [lao_pkg::VAL_W-1:0] pv = (a < lao_pkg::NUM_LIM) ?
		                               procVal0 : procVal1;
		assign overLimit[a]  = pv > limits_ff[a];
		assign belowLimit[a] = pv < limits_ff[a];
		// Widened sum keeps a large deadband from wrapping
		assign belowBand[a]  = ({1'b0, pv} + {1'b0, deadband_ff}) <
		                       {1'b0, limits_ff[a]};
		always_comb begin
			nxt_alarm[a] = alarm_ff[a];
			if (overLimit[a])
				nxt_alarm[a] = 1'b1;
			else if (latch_ff) begin
				if (manualOk && runSel_ff == 3'(a))
					nxt_alarm[a] = 1'b0;
			end else if (belowBand[a])
				nxt_alarm[a] = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			alarm_ff   <= '0;
			runSel_ff  <= 3'h0;
			cleared_ff <= 1'b0;
		end else if (ce) begin
			alarm_ff <= nxt_alarm;
			if (!inSetup && dataRise)
				runSel_ff <= (runSel_ff == lao_pkg::LAST_ALARM) ?
				             3'h0 : runSel_ff + 3'h1;
			if (manualOk)
				cleared_ff <= 1'b1;
			else if (dataRise || setupRise)
				cleared_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs and display
	logic [FLASH_W-1:0] flashCnt_ff;
	logic               flash_ff;
	wire  [3:0]         switchNext;
	wire  [31:0]        showVal =
		!inSetup                           ? {16'h0000, limits_ff[runSel_ff]} :
		(menu_ff == lao_pkg::MENU_FILTER)  ? {25'h0, lao_pkg::lao_filter_value(filter_ff)} :
		(menu_ff == lao_pkg::MENU_DECPT)   ? {30'h0, decpt_ff} :
		(menu_ff == lao_pkg::MENU_LATCH)   ? {31'h0, latch_ff} :
		(menu_ff == lao_pkg::MENU_POLARITY) ? {31'h0, nc_ff[sub_ff]} :
		(menu_ff == lao_pkg::MENU_BUZZER)  ? {31'h0, buzzerOn_ff} :
		editVal;

	// Third limit of each channel has no switched output
	for (genvar s = 0; s < lao_pkg::NUM_SW; s++) begin : g_switch
		localparam int A = (s / 2) * lao_pkg::NUM_LIM + (s % 2);
		assign switchNext[s] = alarm_ff[A] ^ nc_ff[A];
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flashCnt_ff <= '0;
			flash_ff    <= 1'b1;
			limitOut    <= '0;
			alarmLed    <= '0;
			buzzer      <= 1'b0;
			dispValue   <= '0;
			filterValue <= 7'h01;
			decimalPos  <= 2'h0;
			scalerValue <= '0;
			divisorValue <= '0;
		end else if (ce) begin
			flashCnt_ff <= (flashCnt_ff == FLASH_LAST) ? '0 : flashCnt_ff + 1'b1;
			if (flashCnt_ff == FLASH_LAST)
				flash_ff <= ~flash_ff;
			limitOut    <= switchNext;
			alarmLed    <= alarm_ff;
			buzzer      <= buzzerOn_ff &&
			               (alarm_ff[2] || alarm_ff[5]);
			dispValue   <= showVal;
			filterValue <= lao_pkg::lao_filter_value(filter_ff);
			decimalPos  <= decpt_ff;
			scalerValue <= scaler_ff;
			divisorValue <= divisor_ff;
		end
	end

	assign menuItem    = menu_ff;
	assign menuSub     = inSetup ? sub_ff : runSel_ff;
	assign activeDigit = digit_ff;
	assign digitLit    = flash_ff;
	assign clearedMsg  = cleared_ff;

endmodule

// ===== lao_limit_alarm_properties.sv
`timescale 1ns/1ps
module lao_limit_alarm_chk #(
	parameter int FLASH_CYCLES = 4
) (
	input wire logic                          clk,
	input wire logic                          reset,
	input wire logic                          ce,
	input wire logic                          keyData,
	input wire logic                          keyReset,
	input wire logic [lao_pkg::VAL_W-1:0]     procVal0,
	input wire logic [lao_pkg::VAL_W-1:0]     procVal1,
	input wire logic [lao_pkg::NUM_SW-1:0]    limitOut,
	input wire logic [lao_pkg::NUM_ALARM-1:0] alarmLed,
	input wire logic                          buzzer,
	input wire lao_pkg::lao_menu_t            menuItem,
	input wire logic                          digitLit,
	input wire logic                          clearedMsg,
	input wire logic [6:0]                    filterValue,
	input wire logic [lao_pkg::SCALER_W-1:0]  scalerValue
);
	////////////////////////////////////////////////////////////////
	// The first flash period after reset is skipped: its start is unknown
	logic [31:0] flashCnt_ff;
	logic        flashSeen_ff;
	logic        litPrev_ff;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flashCnt_ff  <= 32'h00000000;
			flashSeen_ff <= 1'b0;
			litPrev_ff   <= 1'b1;
		end else if (ce) begin
			// Frozen cycles do not count toward the flash period
			litPrev_ff <= digitLit;
			flashCnt_ff <= (digitLit != litPrev_ff) ? 32'h0 : flashCnt_ff + 1;
			flashSeen_ff <= flashSeen_ff | (digitLit != litPrev_ff);
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_flash_period: assert property (
		(digitLit != litPrev_ff) && flashSeen_ff |->
		flashCnt_ff == FLASH_CYCLES - 1) else $error("flash period wrong");
	a_buzzer_source: assert property (
		buzzer |-> (alarmLed[2] || alarmLed[5])) else $error("stray buzzer");
	a_filter_legal: assert property (
		filterValue inside {7'h01, 7'h02, 7'h04, 7'h06, 7'h0A, 7'h0F,
		7'h14, 7'h1E, 7'h3C}) else $error("filter value illegal");
	a_chan0_cause: assert property (
		(alarmLed[2:0] & ~$past(alarmLed[2:0])) != 3'h0 |->
		$past(procVal0) != 16'h0000) else $error("ch1 alarm uncaused");
	a_chan1_cause: assert property (
		(alarmLed[5:3] & ~$past(alarmLed[5:3])) != 3'h0 |->
		$past(procVal1) != 16'h0000) else $error("ch2 alarm uncaused");
	a_out_follows: assert property (
		menuItem == lao_pkg::MENU_RUN && $past(menuItem) == lao_pkg::MENU_RUN
		|-> (limitOut ^ $past(limitOut)) ==
		({alarmLed[4:3], alarmLed[1:0]} ^ $past({alarmLed[4:3], alarmLed[1:0]})))
		else $error("switched output moved alone");
	a_clear_cause: assert property (
		$rose(clearedMsg) |-> $past(keyReset, 2) && $past(keyData, 2) &&
		menuItem == lao_pkg::MENU_RUN) else $error("clear without keys");
	a_run_cfg_frozen: assert property (
		!$past(reset) && !$past(reset, 2) && menuItem == lao_pkg::MENU_RUN &&
		$past(menuItem) == lao_pkg::MENU_RUN |->
		$stable(filterValue) && $stable(scalerValue))
		else $error("config moved in run");
endmodule

bind lao_limit_alarm lao_limit_alarm_chk #(
	.FLASH_CYCLES(FLASH_CYCLES)
) chk (
	.clk, .reset, .ce, .keyData, .keyReset, .procVal0, .procVal1, .limitOut,
	.alarmLed, .buzzer, .menuItem, .digitLit, .clearedMsg, .filterValue,
	.scalerValue
);

// ===== lao_panel_model.sv
`timescale 1ns/1ps
module lao_panel_model (
	input  wire logic       clk,
	output logic      [5:0] keys
);
	initial keys = 6'h00;
	// Held past the synchroniser, then a gap so the next press is a new edge
	task automatic press(input int k);
		@(negedge clk);
		keys[k] = 1'b1;
		repeat (4) @(negedge clk);
		keys[k] = 1'b0;
		repeat (5) @(negedge clk);
	endtask
	task automatic hold(input int k, input logic v);
		@(negedge clk);
		keys[k] = v;
		repeat (6) @(negedge clk);
	endtask
endmodule

// ===== lao_limit_alarm_tb.sv
`timescale 1ns/1ps
module lao_limit_alarm_tb;
	logic               clk;
	logic               reset;
	logic               ce;
	logic [5:0]         keys;
	logic [2:0]         menuSub;
	logic [31:0]        dispValue;
	logic [2:0]         activeDigit;
	logic [1:0]         decimalPos;
	logic [15:0]        divisorValue;
	logic [15:0]        pv0;
	logic [15:0]        pv1;
	logic [3:0]         limitOut;
	logic [5:0]         alarmLed;
	logic               buzzer;
	lao_pkg::lao_menu_t menuItem;
	logic               digitLit;
	logic               clearedMsg;
	logic [6:0]         filterValue;
	logic [31:0]        scalerValue;
	int                 failures;
	int                 nChecks;
	logic [6:0]         fv [9] = '{7'h01, 7'h02, 7'h04, 7'h06, 7'h0A,
	                               7'h0F, 7'h14, 7'h1E, 7'h3C};

	lao_limit_alarm #(.FLASH_CYCLES(4)) uut (
		.clk(clk), .reset(reset), .ce(ce), .keyUp(keys[0]),
		.keyDown(keys[1]), .keyNext(keys[2]), .keyData(keys[3]),
		.keyReset(keys[4]), .keySetup(keys[5]), .procVal0(pv0),
		.procVal1(pv1), .limitOut(limitOut), .alarmLed(alarmLed),
		.buzzer(buzzer), .menuItem(menuItem), .menuSub(menuSub),
		.dispValue(dispValue), .activeDigit(activeDigit),
		.digitLit(digitLit), .clearedMsg(clearedMsg),
		.filterValue(filterValue), .decimalPos(decimalPos),
		.scalerValue(scalerValue), .divisorValue(divisorValue)
	);
	lao_panel_model pnl (.clk(clk), .keys(keys));

	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input logic [31:0] got, exp, input string what);
		nChecks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic settle();
		repeat (3) @(negedge clk);
	endtask

	task automatic finish_test();
		if (failures == 0 && nChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic t_reset();
		check(limitOut, 4'h0, "limit outputs");
		check(alarmLed, 6'h00, "leds");
		check(filterValue, 7'h01, "filter");
		check(divisorValue, 16'h0001, "divisor");
		check(decimalPos, 2'h0, "decimal");
		check({menuSub, activeDigit}, 6'h00, "sub and digit");
		check(dispValue, 32'h00009999, "run display");
		ce = 1'b0;
		pv1 = 16'hA000;
		settle();
		check(alarmLed, 6'h00, "frozen by ce");
		ce = 1'b1;
		settle();
		check(alarmLed, 6'h38, "ch2 after ce");
		pv1 = 16'h0000;
		settle();
		check(alarmLed, 6'h00, "ch2 release");
	endtask

	task automatic t_edit();
		pnl.press(5);
		repeat (3) pnl.press(3);
		pnl.press(0);
		check(divisorValue, 16'h0002, "divisor digit0");
		pnl.press(2);
		check(activeDigit, 3'h1, "next digit");
		pnl.press(0);
		check(dispValue, 32'h00000012, "divisor shown");
		pnl.press(3);
		check(menuItem, lao_pkg::MENU_LIMIT, "limit item");
		repeat (6) pnl.press(3);
		pnl.press(2);
		pnl.press(0);
		check(dispValue, 32'h00000010, "deadband shown");
		pnl.press(5);
	endtask

	task automatic t_filter();
		pnl.press(5);
		check(menuItem, lao_pkg::MENU_FILTER, "menu");
		for (int i = 1; i <= 9; i++) begin
			pnl.press(0);
			check(filterValue, fv[i % 9], "filter up");
		end
		pnl.press(1);
		check(filterValue, 7'h3C, "filter down wrap");
		pnl.press(5);
	endtask

	task automatic t_auto();
		pv0 = 16'h9999;
		settle();
		check(alarmLed, 6'h00, "equal is not over");
		pv0 = 16'h999A;
		settle();
		check(alarmLed, 6'h07, "ch1 leds");
		check(limitOut, 4'h3, "ch1 outs");
		check(buzzer, 1'b1, "buzzer");
		pv1 = 16'hA000;
		settle();
		check(alarmLed, 6'h3F, "both leds");
		check(limitOut, 4'hF, "both outs");
		pv0 = 16'h9990;
		settle();
		check(alarmLed, 6'h3F, "held by deadband");
		pv0 = 16'h9988;
		settle();
		check(alarmLed, 6'h38, "below band");
		pv0 = 16'h0000;
		pv1 = 16'h0000;
		settle();
		check(alarmLed, 6'h00, "auto release");
		check(limitOut, 4'h0, "auto release outs");
	endtask

	task automatic t_setup();
		pnl.press(5);
		repeat (11) pnl.press(3);
		check(menuItem, lao_pkg::MENU_LATCH, "latch item");
		pnl.press(0);
		pnl.press(3);
		pnl.press(0);
		check(limitOut, 4'h1, "closed output idle");
		repeat (6) pnl.press(3);
		check(menuItem, lao_pkg::MENU_BUZZER, "buzzer item");
		pnl.press(0);
		pnl.press(5);
		check(menuItem, lao_pkg::MENU_RUN, "run");
	endtask

	task automatic t_latch();
		pv0 = 16'hA000;
		settle();
		check(limitOut, 4'h2, "closed output active");
		check(buzzer, 1'b0, "buzzer off");
		pv0 = 16'h0000;
		settle();
		check(alarmLed, 6'h07, "latched");
		pv0 = 16'hA000;
		pnl.hold(3, 1'b1);
		pnl.press(4);
		check(alarmLed, 6'h07, "reset above limit");
		check(clearedMsg, 1'b0, "no message");
		pv0 = 16'h0000;
		settle();
		pnl.press(4);
		check(alarmLed, 6'h05, "second limit cleared");
		check(limitOut, 4'h0, "outputs after clear");
		check(clearedMsg, 1'b1, "cleared message");
		pnl.hold(3, 1'b0);
	endtask

	initial begin
		failures = 0;
		nChecks = 0;
		reset = 1'b1;
		ce = 1'b1;
		pv0 = 16'h0000;
		pv1 = 16'h0000;
		repeat (6) @(negedge clk);
		reset = 1'b0;
		repeat (2) @(negedge clk);
		t_reset();
		t_filter();
		t_edit();
		t_auto();
		t_setup();
		t_latch();
		finish_test();
	end

	// About 600 cycles of key traffic are expected
	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		finish_test();
	end
endmodule
